// ### spaf_pkg.sv
// Shared constants and types for the sequencing pin alternate-function block
package spaf_pkg;
	localparam logic [7:0] ADDR_ALT_ENABLE = 8'h20;
	localparam logic [7:0] ADDR_ALT_SELECT = 8'h21;
	localparam logic [7:0] ADDR_DRIVE_UP   = 8'h22;
	localparam logic [7:0] ADDR_DRIVE_LO   = 8'h23;
	localparam logic [7:0] ADDR_OSC_CFG    = 8'h24;
	localparam logic [7:0] ADDR_GPO        = 8'h25;
	localparam logic [7:0] ADDR_DEBOUNCE   = 8'h26;
	localparam logic [7:0] ADDR_LONG_PRESS = 8'h27;

	localparam int UPPER_PINS = 4;
	localparam int LOWER_PINS = 8;
	localparam logic [7:0] MASK_UPPER  = 8'h0f;
	localparam logic [7:0] MASK_SELECT = 8'h0e;
	localparam logic [7:0] MASK_OSC    = 8'hd0;
	localparam logic [7:0] MASK_DEB    = 8'hfe;
	localparam int IDX_PIN12 = 3;
	localparam int IDX_PIN11 = 2;
	localparam int IDX_PIN10 = 1;
	localparam int OSC_CAP_BIT = 7;
	localparam int OSC_XTAL_BIT = 6;
	localparam int OSC_CLKOUT_BIT = 4;
	localparam int DEB_FIELD_LSB = 4;
	localparam int DEB_FIELD_W = 4;

	localparam int CLK_PERIOD_NS = 20;
	localparam int MS_IN_NS = 1000000;
	localparam int CYCLES_PER_MS = MS_IN_NS / CLK_PERIOD_NS;
	localparam int DEB_STEP_MS = 5;
	localparam int LP_STEP_MS = 100;
	localparam int MS_CNT_W = 15;

	typedef struct packed {
		logic [7:0] alt_function_enable;
		logic [7:0] alt_function_select;
		logic [7:0] pin_drive_mode_upper;
		logic [7:0] pin_drive_mode_lower;
		logic [7:0] oscillator_config;
		logic [7:0] general_output_state;
		logic [7:0] input_debounce_config;
		logic [7:0] long_press_threshold;
	} spaf_nvm_s;

	typedef struct packed {
		logic       power_button_n;
		logic       external_reset_n;
		logic       emergency_powerdown_n;
	} spaf_inputs_s;
endpackage : spaf_pkg

// ### spaf_debounce.sv
// Input filter that takes a new level after it holds for a set number of ms ticks
`timescale 1ns/1ns
module spaf_debounce import spaf_pkg::*; #(
	parameter int CNT_W = 8
) (
	input  wire logic             sys_clk,
	input  wire logic             rst,
	input  wire logic             ce,
	input  wire logic             ms_tick,
	input  wire logic             filter_on,
	input  wire logic [CNT_W-1:0] period_ms,
	input  wire logic             raw_in,
	output logic                  level_out
);
	logic             level_q;
	logic [CNT_W-1:0] cnt_q;
	wire              differs  = raw_in != level_q;
	wire              expired  = ms_tick && (cnt_q + 1'b1 >= period_ms);

	assign level_out = level_q;

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			level_q <= 1'b1;
			cnt_q   <= '0;
		end else if (ce) begin
			if (!filter_on || !differs) begin
				cnt_q <= '0;
				level_q <= raw_in;
			end else if (expired) begin
				cnt_q <= '0;
				level_q <= raw_in; // RULE19
			end else if (ms_tick) begin
				cnt_q <= cnt_q + 1'b1;
			end
		end
	end

	AST_FILTER_HOLDS: assert property (@(posedge sys_clk) disable iff (rst) // RULE19
		ce && filter_on && differs && !ms_tick |=> $stable(level_q))
		else $error("filtered level moved without a ms tick");
endmodule : spaf_debounce

// ### spaf_pin_mux.sv
// Alternate-function pin mux, drive modes, input filters and long-press timing
// Operation
// RULE1 - Per-pin enable bits 3..0 for pins 12..9
// RULE2 - Alternate use only with zero sequencing fields
// RULE3 - Pin12 select: output or power button
// RULE4 - Pin11 select: output or reset input
// RULE5 - Pin10 select: output or emergency input
// RULE6 - Pin9 select bit reads zero always
// RULE7 - Selection applies only when enable set
// RULE8 - Drive bits: zero open drain, one push-pull
// RULE9 - Config registers load from NVM, read-only
// RULE10 - Oscillator bits set crystal and load cap
// RULE11 - Bit4 sets slow clock output drive
// RULE12 - Output bits drive pins when sequencing clear
// RULE13 - Writable registers locked when group protected
// RULE14 - Debounce time is five ms times (n+1)
// RULE15 - Bits 3..1 enable filtering per input
// RULE16 - Long press threshold is (n+1) times 100ms
// RULE17 - Reset input drives reset and records cause
// RULE18 - Emergency input triggers shutdown, records cause
// RULE19 - New level accepted after full stable period
`timescale 1ns/1ns
module spaf_pin_mux import spaf_pkg::*; #(
	parameter int MS_CYCLES = CYCLES_PER_MS
) (
	input  wire logic                  sys_clk,
	input  wire logic                  rst,
	input  wire logic                  ce,
	input  wire logic                  nvm_load,
	input  wire spaf_nvm_s             nvm_image,
	input  wire logic                  control_group_protected,
	input  wire logic [7:0]            reg_addr,
	input  wire logic                  reg_wr,
	input  wire logic [7:0]            reg_wdata,
	input  wire logic                  reg_rd,
	output logic      [7:0]            reg_rdata,
	input  wire logic [UPPER_PINS-1:0] seq_fields_zero,
	input  wire logic [UPPER_PINS-1:0] power_sequence_use,
	input  wire logic [UPPER_PINS-1:0] sleep_sequence_use,
	input  wire logic [UPPER_PINS-1:0] seq_level_upper,
	input  wire logic [LOWER_PINS-1:0] seq_level_lower,
	input  wire logic [UPPER_PINS-1:0] pin_in_upper,
	output logic      [UPPER_PINS-1:0] pin_out_upper,
	output logic      [UPPER_PINS-1:0] pin_oe_n_upper,
	output logic      [LOWER_PINS-1:0] pin_out_lower,
	output logic      [LOWER_PINS-1:0] pin_oe_n_lower,
	output spaf_inputs_s               decoded_inputs,
	output logic                       reset_output_n,
	output logic                       reset_cause_pulse,
	output logic                       emergency_shutdown_pulse,
	output logic                       short_press_pulse,
	output logic                       long_press_pulse,
	output logic                       crystal_driver_on,
	output logic                       crystal_cap_select,
	output logic                       slow_clock_out_drive
);
	spaf_nvm_s             cfg_q;
	logic [7:0]            rdata_q;
	logic [31:0]           pre_q;
	logic                  ms_tick_q;
	logic                  btn_prev_q;
	logic                  rst_prev_q;
	logic                  em_prev_q;
	logic [MS_CNT_W-1:0]   press_q;
	logic                  long_seen_q;
	logic                  rst_cause_q;
	logic                  em_cause_q;
	logic                  short_q;
	logic                  long_q;
	logic [UPPER_PINS-1:0] filt;

	// Pin 9 select bit is held at zero
	wire [UPPER_PINS-1:0] alt_select = cfg_q.alt_function_select[UPPER_PINS-1:0]; // RULE6
	wire [UPPER_PINS-1:0] alt_ok = cfg_q.alt_function_enable[UPPER_PINS-1:0]
		& seq_fields_zero; // RULE1 RULE2
	wire [UPPER_PINS-1:0] as_input = alt_ok & alt_select; // RULE3 RULE4 RULE5 RULE7
	wire [UPPER_PINS-1:0] as_output = alt_ok & ~alt_select; // RULE7
	wire [UPPER_PINS-1:0] gpo_live = as_output & ~power_sequence_use
		& ~sleep_sequence_use; // RULE12
	wire [UPPER_PINS-1:0] gpo_bits = cfg_q.general_output_state[UPPER_PINS-1:0];
	wire [UPPER_PINS-1:0] drive_up = cfg_q.pin_drive_mode_upper[UPPER_PINS-1:0];
	// Per pin: live output bit, released input, or sequencing level when locked
	wire [UPPER_PINS-1:0] level_up = (gpo_live & gpo_bits) | as_input
		| (~alt_ok & seq_level_upper); // RULE12
	wire [UPPER_PINS-1:0] raw_in = pin_in_upper | ~as_input;

	wire [DEB_FIELD_W-1:0] deb_field =
		cfg_q.input_debounce_config[DEB_FIELD_LSB +: DEB_FIELD_W];
	wire [7:0] deb_ms = 8'(DEB_STEP_MS) * (8'(deb_field) + 8'h01); // RULE14
	wire [UPPER_PINS-1:0] filter_on = cfg_q.input_debounce_config[UPPER_PINS-1:0]; // RULE15
	wire [MS_CNT_W-1:0] lp_ms = MS_CNT_W'(LP_STEP_MS)
		* (MS_CNT_W'(cfg_q.long_press_threshold) + 15'h0001); // RULE16

	wire btn_n = filt[IDX_PIN12];
	wire ext_rst_n = filt[IDX_PIN11];
	wire em_n = filt[IDX_PIN10];
	wire wr_ok = reg_wr && !control_group_protected; // RULE13
	wire press_done = press_q + 15'h0001 >= lp_ms;

	// Open drain drives only lows; push-pull drives both levels
	assign pin_out_upper = level_up & drive_up & ~as_input; // RULE8
	assign pin_oe_n_upper = as_input | (level_up & ~drive_up); // RULE8
	assign pin_out_lower = seq_level_lower & cfg_q.pin_drive_mode_lower; // RULE8
	assign pin_oe_n_lower = seq_level_lower & ~cfg_q.pin_drive_mode_lower; // RULE8

	assign crystal_driver_on = cfg_q.oscillator_config[OSC_XTAL_BIT]; // RULE10
	assign crystal_cap_select = cfg_q.oscillator_config[OSC_CAP_BIT]; // RULE10
	assign slow_clock_out_drive = cfg_q.oscillator_config[OSC_CLKOUT_BIT]; // RULE11

	assign decoded_inputs = '{power_button_n: btn_n, external_reset_n: ext_rst_n,
		emergency_powerdown_n: em_n};
	assign reset_output_n = ext_rst_n; // RULE17
	assign reset_cause_pulse = rst_cause_q;
	assign emergency_shutdown_pulse = em_cause_q;
	assign short_press_pulse = short_q;
	assign long_press_pulse = long_q;
	assign reg_rdata = rdata_q;

	genvar gi;
	generate
		for (gi = 1; gi < UPPER_PINS; gi = gi + 1) begin : g_filt
			spaf_debounce #(.CNT_W(8)) u_deb (
				.sys_clk   (sys_clk),
				.rst       (rst),
				.ce        (ce),
				.ms_tick   (ms_tick_q),
				.filter_on (filter_on[gi]),
				.period_ms (deb_ms),
				.raw_in    (raw_in[gi]),
				.level_out (filt[gi])
			);
		end
	endgenerate
	assign filt[0] = 1'b1;

	// Config load and software writes
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			cfg_q <= '0;
		end else if (ce) begin
			if (nvm_load) begin
				cfg_q <= nvm_image; // RULE9
				cfg_q.alt_function_select <= nvm_image.alt_function_select & MASK_SELECT; // RULE6
			end else if (wr_ok) begin
				if (reg_addr == ADDR_GPO)
					cfg_q.general_output_state <= reg_wdata & MASK_UPPER;
				if (reg_addr == ADDR_DEBOUNCE)
					cfg_q.input_debounce_config <= reg_wdata & MASK_DEB;
				if (reg_addr == ADDR_LONG_PRESS)
					cfg_q.long_press_threshold <= reg_wdata;
			end
		end
	end

	// Read data; reserved bits and unmapped addresses read zero
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			rdata_q <= '0;
		end else if (ce && reg_rd) begin
			case (reg_addr)
				ADDR_ALT_ENABLE: rdata_q <= cfg_q.alt_function_enable & MASK_UPPER;
				ADDR_ALT_SELECT: rdata_q <= cfg_q.alt_function_select & MASK_SELECT;
				ADDR_DRIVE_UP:   rdata_q <= cfg_q.pin_drive_mode_upper & MASK_UPPER;
				ADDR_DRIVE_LO:   rdata_q <= cfg_q.pin_drive_mode_lower;
				ADDR_OSC_CFG:    rdata_q <= cfg_q.oscillator_config & MASK_OSC;
				ADDR_GPO:        rdata_q <= cfg_q.general_output_state & MASK_UPPER;
				ADDR_DEBOUNCE:   rdata_q <= cfg_q.input_debounce_config & MASK_DEB;
				ADDR_LONG_PRESS: rdata_q <= cfg_q.long_press_threshold;
				default:         rdata_q <= '0;
			endcase
		end
	end

	// Millisecond tick
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			pre_q <= '0;
			ms_tick_q <= 1'b0;
		end else if (ce) begin
			ms_tick_q <= (pre_q == 32'(MS_CYCLES - 1));
			pre_q <= (pre_q == 32'(MS_CYCLES - 1)) ? '0 : pre_q + 32'h1;
		end
	end

	// Falling-edge causes and press classification
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			btn_prev_q <= 1'b1;
			rst_prev_q <= 1'b1;
			em_prev_q <= 1'b1;
			rst_cause_q <= 1'b0;
			em_cause_q <= 1'b0;
			short_q <= 1'b0;
			long_q <= 1'b0;
			press_q <= '0;
			long_seen_q <= 1'b0;
		end else if (ce) begin
			btn_prev_q <= btn_n;
			rst_prev_q <= ext_rst_n;
			em_prev_q <= em_n;
			rst_cause_q <= rst_prev_q && !ext_rst_n; // RULE17
			em_cause_q <= em_prev_q && !em_n; // RULE18
			short_q <= !btn_prev_q && btn_n && !long_seen_q; // RULE16
			long_q <= 1'b0;
			if (btn_n) begin
				press_q <= '0;
				long_seen_q <= 1'b0;
			end else if (ms_tick_q && !long_seen_q) begin
				if (press_done) begin
					long_q <= 1'b1; // RULE16
					long_seen_q <= 1'b1;
				end else begin
					press_q <= press_q + 15'h0001;
				end
			end
		end
	end

	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (rst);

	sequence s_protected_write;
		ce && !nvm_load && reg_wr && control_group_protected;
	endsequence
	sequence s_reset_fall;
		ce && rst_prev_q && !ext_rst_n;
	endsequence
	sequence s_open_write;
		ce && !nvm_load && wr_ok && reg_addr == ADDR_GPO;
	endsequence
	sequence s_button_release;
		ce && !btn_prev_q && btn_n && !long_seen_q;
	endsequence

	AST_SELECT9_ZERO: assert property (!cfg_q.alt_function_select[0]) // RULE6
		else $error("pin9 select bit set");
	AST_LOCKED_TO_SEQ: assert property (!seq_fields_zero[IDX_PIN12] // RULE2
		|-> (pin_out_upper[IDX_PIN12] == (seq_level_upper[IDX_PIN12] & drive_up[IDX_PIN12])))
		else $error("locked pin not following sequencing level");
	AST_INPUT_RELEASED: assert property (alt_ok[IDX_PIN11] && alt_select[IDX_PIN11] // RULE4
		|-> pin_oe_n_upper[IDX_PIN11])
		else $error("input pin driven");
	AST_GPO_LEVEL: assert property (gpo_live[0] && drive_up[0] // RULE12
		|-> pin_out_upper[0] == gpo_bits[0] && !pin_oe_n_upper[0])
		else $error("general output not driven");
	AST_PROTECT: assert property (s_protected_write |=> $stable(cfg_q)) // RULE13
		else $error("protected register changed");
	AST_RO_CONFIG: assert property (ce && !nvm_load |=> // RULE9
		$stable(cfg_q.alt_function_enable) && $stable(cfg_q.oscillator_config))
		else $error("read-only config changed without load");
	AST_RESET_CAUSE: assert property (s_reset_fall |=> reset_cause_pulse ##1 // RULE17
		(!reset_cause_pulse || !$past(ce)))
		else $error("reset cause not recorded");
	AST_RESET_OUT: assert property (!ext_rst_n |-> !reset_output_n) // RULE17
		else $error("reset output not asserted");
	AST_EMERGENCY: assert property (ce && em_prev_q && !em_n // RULE18
		|=> emergency_shutdown_pulse)
		else $error("emergency shutdown missed");
	AST_OPEN_DRAIN_LO: assert property (!cfg_q.pin_drive_mode_lower[0] // RULE8
		|-> !pin_out_lower[0])
		else $error("open drain pin drove high");
	AST_LONG_PULSE: assert property (ce && !btn_n && ms_tick_q && !long_seen_q && press_done // RULE16
		|=> long_press_pulse)
		else $error("long press not flagged");

	// Pin drive checks
	AST_PUSH_PULL_LO: assert property (cfg_q.pin_drive_mode_lower[0] // RULE8
		|-> !pin_oe_n_lower[0] && pin_out_lower[0] == seq_level_lower[0])
		else $error("push-pull pin not driven");
	AST_LOCKED_OE: assert property (!seq_fields_zero[IDX_PIN11] // RULE2
		|-> pin_oe_n_upper[IDX_PIN11] == (seq_level_upper[IDX_PIN11] & ~drive_up[IDX_PIN11]))
		else $error("locked pin enable wrong");
	AST_GPO_OFF: assert property (as_output[0] && !gpo_live[0] // RULE12
		|-> !pin_out_upper[0] && !pin_oe_n_upper[0])
		else $error("held general output not driven low");

	// Register and input path checks
	AST_NVM_LOAD: assert property (ce && nvm_load |=> // RULE9
		cfg_q.alt_function_enable == $past(nvm_image.alt_function_enable)
		&& cfg_q.oscillator_config == $past(nvm_image.oscillator_config))
		else $error("configuration not loaded");
	AST_GPO_WRITE: assert property (s_open_write |=> // RULE13
		cfg_q.general_output_state == ($past(reg_wdata) & MASK_UPPER))
		else $error("output register write lost");
	AST_SELECT_READ: assert property (ce && reg_rd && reg_addr == ADDR_ALT_SELECT // RULE6
		|=> !reg_rdata[0])
		else $error("pin9 select bit read back set");
	AST_UNSELECTED_HIGH: assert property (ce && !as_input[IDX_PIN10] // RULE7
		&& !filter_on[IDX_PIN10] |=> em_n)
		else $error("unselected input not high");
	AST_FILTER_OFF: assert property (ce && !filter_on[IDX_PIN11] // RULE15
		|=> ext_rst_n == $past(raw_in[IDX_PIN11]))
		else $error("unfiltered input not passed through");
	AST_FREEZE: assert property (!ce |=>
		$stable(cfg_q) && $stable(rdata_q) && $stable(press_q))
		else $error("state moved while clock enable low");

	// Press and cause pulse checks
	AST_SHORT_PRESS: assert property (s_button_release |=> short_press_pulse) // RULE16
		else $error("short press not flagged");
	AST_LONG_ONCE: assert property (ce && long_press_pulse |=> !long_press_pulse) // RULE16
		else $error("long press pulse stretched");
	AST_PRESS_CLEAR: assert property (ce && btn_n |=> press_q == '0) // RULE16
		else $error("press counter kept while released");
	AST_EM_ONE: assert property (ce && emergency_shutdown_pulse // RULE18
		|=> !emergency_shutdown_pulse)
		else $error("emergency pulse stretched");
endmodule : spaf_pin_mux

// ### spaf_far_side.sv
// Far-side model: pull-ups on the upper enable lines, switches pulling inputs low
`timescale 1ns/1ns
module spaf_far_side (
	input  wire logic [3:0] pin_out,
	input  wire logic [3:0] pin_oe_n,
	input  wire logic [3:0] press,
	output logic      [3:0] pin_level
);
	// A released line sits at its pull-up unless a switch pulls it low
	always_comb begin
		for (int i = 0; i < 4; i++) begin
			pin_level[i] = !pin_oe_n[i] ? pin_out[i] : !press[i];
		end
	end
endmodule : spaf_far_side

// ### testbench.sv
// Self-checking bench for the sequencing pin alternate-function block
`timescale 1ns/1ns
module testbench import spaf_pkg::*;;
	typedef struct {int k; logic [31:0] v;} spaf_note_s;
	localparam logic [7:0] MSK [8] = '{MASK_UPPER, MASK_SELECT, MASK_UPPER, 8'hff,
		MASK_OSC, MASK_UPPER, MASK_DEB, 8'hff};
	logic sys_clk = 0, rst = 1, ce = 1, nvm_load = 0, prot = 0, reg_wr = 0, reg_rd = 0;
	logic snap = 0, rst_n, p_rc, p_em, p_sh, p_lp, xd, xc, ck;
	logic [7:0] reg_addr = '0, reg_wdata = '0, reg_rdata, seql = '0, out_l, oe_l;
	logic [3:0] sfz = '0, pwr = '0, slp = '0, sequ = '0, press = '0, pin_in, pin_out, oe_u;
	logic [7:0] m [8];
	logic [2:0] dm = 3'b111;
	logic [31:0] seed = 32'h44e7ac3a;
	spaf_nvm_s img = '0;
	spaf_inputs_s dec;
	spaf_note_s q [$];
	int num_errors = 0;
	int comparisons = 0;

	always #10 sys_clk = ~sys_clk;

	spaf_pin_mux #(.MS_CYCLES(10)) i_dut (.sys_clk, .rst, .ce, .nvm_load, .nvm_image(img),
		.control_group_protected(prot), .reg_addr, .reg_wr, .reg_wdata, .reg_rd, .reg_rdata,
		.seq_fields_zero(sfz), .power_sequence_use(pwr), .sleep_sequence_use(slp),
		.seq_level_upper(sequ), .seq_level_lower(seql), .pin_in_upper(pin_in),
		.pin_out_upper(pin_out), .pin_oe_n_upper(oe_u), .pin_out_lower(out_l),
		.pin_oe_n_lower(oe_l), .decoded_inputs(dec), .reset_output_n(rst_n),
		.reset_cause_pulse(p_rc), .emergency_shutdown_pulse(p_em), .short_press_pulse(p_sh),
		.long_press_pulse(p_lp), .crystal_driver_on(xd), .crystal_cap_select(xc),
		.slow_clock_out_drive(ck));
	spaf_far_side i_far (.pin_out, .pin_oe_n(oe_u), .press, .pin_level(pin_in));

	function automatic logic [31:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction : xs

	function automatic logic [31:0] snap_exp();
		logic [3:0] po, pe;
		logic l, alt;
		for (int i = 0; i < 4; i++) begin
			alt = m[0][i] && sfz[i];
			if (alt && !m[1][i]) l = (pwr[i] | slp[i]) ? 1'b0 : m[5][i];
			else if (alt) l = 1'b1;
			else l = sequ[i];
			po[i] = m[2][i] & l;
			pe[i] = !m[2][i] & l;
		end
		return {1'b0, dm, dm[1], m[4][7], m[4][6], m[4][4], po, pe, m[3] & seql, ~m[3] & seql};
	endfunction : snap_exp

	task automatic finish_test();
		$display("errors %0d comparisons %0d", num_errors, comparisons);
		if (num_errors == 0 && comparisons > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask : finish_test

	task automatic check(input logic [39:0] seen, input logic [39:0] exp);
		comparisons++;
		if (seen !== exp) begin
			num_errors++;
			$display("unexpected at %0t: saw %h want %h", $time, seen, exp);
		end
	endtask : check

	task automatic got(input int k, input logic [31:0] v);
		spaf_note_s n;
		if (q.size() == 0) begin
			num_errors++;
			$display("unexpected at %0t: stray result kind %0d", $time, k);
		end else begin
			n = q.pop_front();
			check({k[7:0], v}, {n.k[7:0], n.v});
		end
	endtask : got

	always @(posedge sys_clk) begin : watch
		logic r, s;
		r = reg_rd && ce;
		s = snap;
		#1;
		if (r) got(1, {24'h0, reg_rdata});
		if (s) got(2, {1'b0, dec, rst_n, xc, xd, ck, pin_out, oe_u, out_l, oe_l});
		if (p_rc | p_em | p_sh | p_lp) got(3, {28'h0, p_rc, p_em, p_sh, p_lp});
	end

	task automatic note(input int k, input logic [31:0] v);
		q.push_back('{k, v});
	endtask : note

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(negedge sys_clk);
		reg_addr = a;
		reg_wdata = d[7:0];
		reg_wr = 1;
		if (!prot && ce && a >= ADDR_GPO && a <= ADDR_LONG_PRESS)
			m[a[2:0]] = d[7:0] & MSK[a[2:0]];
		@(negedge sys_clk);
		reg_wr = 0;
	endtask : wr

	task automatic rd(input logic [7:0] a);
		@(negedge sys_clk);
		reg_addr = a;
		reg_rd = 1;
		note(1, {24'h0, m[a[2:0]]});
		@(negedge sys_clk);
		reg_rd = 0;
	endtask : rd

	task automatic sn();
		@(negedge sys_clk);
		snap = 1;
		note(2, snap_exp());
		@(negedge sys_clk);
		snap = 0;
	endtask : sn

	task automatic load(input spaf_nvm_s v);
		@(negedge sys_clk);
		img = v;
		nvm_load = 1;
		for (int i = 0; i < 8; i++) m[i] = v[63-8*i -: 8] & MSK[i];
		@(negedge sys_clk);
		nvm_load = 0;
	endtask : load

	task automatic drain();
		for (int t = 0; t < 3000 && q.size() > 0; t++) @(negedge sys_clk);
		if (q.size() > 0) begin
			num_errors++;
			$display("unexpected at %0t: result never came", $time);
			finish_test();
		end
	endtask : drain

	// Hold a switch on pin index i; p1 is due while held, p2 after release
	task automatic hold(input int i, input int n, input logic [3:0] p1, p2, input logic low);
		@(negedge sys_clk);
		press[i] = 1;
		if (p1 != 0) note(3, {28'h0, p1});
		repeat (n) @(negedge sys_clk);
		if (low) dm[i-1] = 0;
		sn();
		press[i] = 0;
		if (p2 != 0) note(3, {28'h0, p2});
		dm[i-1] = 1;
		repeat (150) @(negedge sys_clk);
		drain();
		sn();
	endtask : hold

	initial begin
		spaf_nvm_s v;
		logic [31:0] r;
		repeat (8) @(negedge sys_clk);
		rst = 0;
		repeat (12) begin
			v = {xs(), xs()};
			v.pin_drive_mode_upper &= ~(v.alt_function_select & MASK_SELECT);
			load(v);
			r = xs();
			{sfz, pwr, slp, sequ} = r[15:0];
			seql = r[23:16];
			sn();
			for (int a = 0; a < 8; a++) rd(ADDR_ALT_ENABLE + a[7:0]);
		end
		v = '0;
		v.alt_function_enable = MASK_UPPER;
		v.alt_function_select = MASK_SELECT;
		load(v);
		{sfz, pwr, slp} = {4'hf, 4'h0, 4'h0};
		for (int p = 1; p >= 0; p--) begin
			prot = p[0];
			for (int a = 0; a < 9; a++) wr((a < 8) ? ADDR_ALT_ENABLE + a[7:0] : 8'h30, xs());
			sn();
			for (int a = 0; a < 8; a++) rd(ADDR_ALT_ENABLE + a[7:0]);
		end
		// Clock enable low: a write is dropped and nothing moves
		ce = 0;
		wr(ADDR_GPO, 32'h5);
		sn();
		ce = 1;
		rd(ADDR_GPO);
		pwr = 4'hf;
		sn();
		pwr = 4'h0;
		wr(ADDR_DEBOUNCE, 8'h00);
		wr(ADDR_LONG_PRESS, 8'h00);
		hold(IDX_PIN10, 70, 4'b0100, 4'b0000, 1);
		hold(IDX_PIN11, 70, 4'b1000, 4'b0000, 1);
		hold(IDX_PIN12, 300, 4'b0000, 4'b0010, 1);
		hold(IDX_PIN12, 1100, 4'b0001, 4'b0000, 1);
		wr(ADDR_LONG_PRESS, 8'h01);
		hold(IDX_PIN12, 1500, 4'b0000, 4'b0010, 1);
		wr(ADDR_DEBOUNCE, 8'h02);
		hold(IDX_PIN10, 30, 4'b0000, 4'b0000, 0);
		hold(IDX_PIN10, 70, 4'b0100, 4'b0000, 1);
		wr(ADDR_DEBOUNCE, 8'h12);
		hold(IDX_PIN10, 80, 4'b0000, 4'b0000, 0);
		hold(IDX_PIN10, 130, 4'b0100, 4'b0000, 1);
		drain();
		finish_test();
	end
endmodule : testbench
